// ---- rtl/sis_pkg.sv ----
// Package of register map, field layout and constants for the status, interrupt and soft reset block.
package sis_pkg;
    localparam int unsigned           SIS_DW          = 16;
    localparam int unsigned           SIS_AW          = 8;
    localparam logic [SIS_AW-1:0]     ADDR_SOFT_RESET = 8'h00;
    localparam logic [SIS_AW-1:0]     ADDR_STATUS_A   = 8'h01;
    localparam logic [SIS_AW-1:0]     ADDR_STATUS_B   = 8'h02;
    localparam logic [SIS_AW-1:0]     ADDR_ENABLE_A   = 8'h03;
    localparam logic [SIS_AW-1:0]     ADDR_ENABLE_B   = 8'h04;
    localparam logic [SIS_DW-1:0]     SOFT_RESET_KEY  = 16'h789A;
    localparam logic [SIS_DW-1:0]     REG_RESET_VAL   = 16'h0000;
    localparam logic [SIS_DW-1:0]     READ_ZERO       = 16'h0000;
    // Status A bit positions.
    localparam int unsigned           BIT_CSUM_A      = 14;
    localparam int unsigned           BIT_CSUM_B      = 12;
    localparam int unsigned           BIT_CSUM_C      = 10;
    localparam int unsigned           BIT_CSUM_D      = 8;
    localparam int unsigned           BIT_VSEQ        = 7;
    localparam int unsigned           BIT_ISEQ        = 6;
    localparam int unsigned           BIT_SAG         = 3;
    localparam int unsigned           BIT_PLOSS       = 2;
    // Implemented bits; reserved bits read as zero.
    localparam logic [SIS_DW-1:0]     STATUS_A_MASK   = 16'h55CC;
    localparam logic [SIS_DW-1:0]     CSUM_MASK       = 16'h5500;
    localparam logic [SIS_DW-1:0]     STATUS_B_MASK   = 16'hCEFF;

    typedef struct packed {
        logic                         wr;
        logic                         rd;
        logic [SIS_AW-1:0]            addr;
        logic [SIS_DW-1:0]            wdata;
    } sis_req_t;

    typedef struct packed {
        logic                         csum_a;
        logic                         csum_b;
        logic                         csum_c;
        logic                         csum_d;
        logic                         vseq;
        logic                         iseq;
        logic                         sag;
        logic                         ploss;
    } sis_cond_a_t;
endpackage

// ---- rtl/sis_status_irq.sv ----
// Soft reset key register, two read-to-clear status registers, enables, interrupt and warning outputs.
// Operation
// - Soft reset register at offset 00H, write only, default zero.
// - Only the key 789AH triggers a full reset; other values are ignored.
// - Soft reset clears the status and enable registers, as the reset pin does; read data is not cleared.
// - Reading the soft reset register always returns zero.
// - Interrupt A asserts when any status A bit and its enable are set.
// - Interrupt B asserts when any status B bit and its enable are set.
// - Status A at offset 01H, resets to zero, cleared by a read.
// - Checksum A error flag, set on mismatch, zero when correct.
// - Status bit 12 reports checksum B mismatch.
// - Status bit 10 reports checksum C mismatch.
// - Status bit 8 reports checksum D mismatch.
// - Any checksum error asserts the warning output at once, ignoring enables.
// - Status bit 7 flags a wrong voltage phase sequence.
// - Status bit 6 flags a wrong current phase sequence.
// - Status bit 3 flags voltage sag on one or more phases.
// - Status bit 2 flags voltage loss on one or more phases.
// - Enable bits share status bit positions, default disabled.
// - Status B at offset 02H, read-to-clear, resets to zero.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module sis_status_irq (
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_rst,
    input  wire sis_pkg::sis_req_t             i_req,
    output logic        [sis_pkg::SIS_DW-1:0]  o_rdata,
    input  wire sis_pkg::sis_cond_a_t          i_cond_a,
    input  wire logic   [sis_pkg::SIS_DW-1:0]  i_cond_b,
    output logic                               o_interrupt_out_a,
    output logic                               o_interrupt_out_b,
    output logic                               o_warning_out,
    output logic                               o_soft_reset
);
    // Detector levels come from the same clock; no synchroniser needed.
    logic [sis_pkg::SIS_DW-1:0] system_status_a_q;
    logic [sis_pkg::SIS_DW-1:0] system_status_b_q;
    logic [sis_pkg::SIS_DW-1:0] interrupt_enable_a_q;
    logic [sis_pkg::SIS_DW-1:0] interrupt_enable_b_q;
    logic [sis_pkg::SIS_DW-1:0] cond_a_vec;
    logic [sis_pkg::SIS_DW-1:0] cond_b_vec;
    logic                       soft_reset_q;
    logic                       key_hit;
    logic                       rd_a;
    logic                       rd_b;
    logic                       rst_all;

    always_comb begin
        cond_a_vec = '0;
        cond_a_vec[sis_pkg::BIT_CSUM_A] = i_cond_a.csum_a;
        cond_a_vec[sis_pkg::BIT_CSUM_B] = i_cond_a.csum_b;
        cond_a_vec[sis_pkg::BIT_CSUM_C] = i_cond_a.csum_c;
        cond_a_vec[sis_pkg::BIT_CSUM_D] = i_cond_a.csum_d;
        cond_a_vec[sis_pkg::BIT_VSEQ]   = i_cond_a.vseq;
        cond_a_vec[sis_pkg::BIT_ISEQ]   = i_cond_a.iseq;
        cond_a_vec[sis_pkg::BIT_SAG]    = i_cond_a.sag;
        cond_a_vec[sis_pkg::BIT_PLOSS]  = i_cond_a.ploss;
    end
    assign cond_b_vec = i_cond_b & sis_pkg::STATUS_B_MASK;

    assign key_hit = i_req.wr && (i_req.addr == sis_pkg::ADDR_SOFT_RESET)
                     && (i_req.wdata == sis_pkg::SOFT_RESET_KEY);
    assign rd_a    = i_req.rd && (i_req.addr == sis_pkg::ADDR_STATUS_A);
    assign rd_b    = i_req.rd && (i_req.addr == sis_pkg::ADDR_STATUS_B);

    // The key write is held one cycle and then acts as a synchronous reset of the status and enable registers,
    // so the write that carries it finishes cleanly before anything is cleared.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            soft_reset_q <= 1'b0;
        end else begin
            soft_reset_q <= key_hit;
        end
    end
    assign rst_all      = soft_reset_q;
    assign o_soft_reset = soft_reset_q;

    // A condition present in the read cycle is kept: set wins over the clear of the read.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            system_status_a_q <= sis_pkg::REG_RESET_VAL;
        end else if (rst_all) begin
            system_status_a_q <= sis_pkg::REG_RESET_VAL;
        end else if (rd_a) begin
            system_status_a_q <= cond_a_vec;
        end else begin
            system_status_a_q <= system_status_a_q | cond_a_vec;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            system_status_b_q <= sis_pkg::REG_RESET_VAL;
        end else if (rst_all) begin
            system_status_b_q <= sis_pkg::REG_RESET_VAL;
        end else if (rd_b) begin
            system_status_b_q <= cond_b_vec;
        end else begin
            system_status_b_q <= system_status_b_q | cond_b_vec;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            interrupt_enable_a_q <= sis_pkg::REG_RESET_VAL;
            interrupt_enable_b_q <= sis_pkg::REG_RESET_VAL;
        end else if (rst_all) begin
            interrupt_enable_a_q <= sis_pkg::REG_RESET_VAL;
            interrupt_enable_b_q <= sis_pkg::REG_RESET_VAL;
        end else if (i_req.wr) begin
            if (i_req.addr == sis_pkg::ADDR_ENABLE_A) begin
                interrupt_enable_a_q <= i_req.wdata & sis_pkg::STATUS_A_MASK;
            end
            if (i_req.addr == sis_pkg::ADDR_ENABLE_B) begin
                interrupt_enable_b_q <= i_req.wdata & sis_pkg::STATUS_B_MASK;
            end
        end
    end

    // Read data stands in the cycle after the strobe only; unmapped addresses read zero.
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= sis_pkg::READ_ZERO;
        end else if (i_req.rd) begin
            case (i_req.addr)
                sis_pkg::ADDR_SOFT_RESET: o_rdata <= sis_pkg::READ_ZERO;
                sis_pkg::ADDR_STATUS_A:   o_rdata <= system_status_a_q;
                sis_pkg::ADDR_STATUS_B:   o_rdata <= system_status_b_q;
                sis_pkg::ADDR_ENABLE_A:   o_rdata <= interrupt_enable_a_q;
                sis_pkg::ADDR_ENABLE_B:   o_rdata <= interrupt_enable_b_q;
                default:                  o_rdata <= sis_pkg::READ_ZERO;
            endcase
        end else begin
            o_rdata <= sis_pkg::READ_ZERO;
        end
    end

    assign o_interrupt_out_a = |(system_status_a_q & interrupt_enable_a_q);
    assign o_interrupt_out_b = |(system_status_b_q & interrupt_enable_b_q);
    // Warning follows the sticky flags or the live condition, so it rises in the same cycle.
    assign o_warning_out = |((system_status_a_q | cond_a_vec) & sis_pkg::CSUM_MASK);

    sequence seq_key_write;
        key_hit;
    endsequence

    sequence seq_block_cleared;
        ##1 soft_reset_q ##1 (system_status_a_q == sis_pkg::REG_RESET_VAL || |cond_a_vec)
            && interrupt_enable_a_q == sis_pkg::REG_RESET_VAL;
    endsequence

    AST_KEY_RESET: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        seq_key_write |-> seq_block_cleared)
        else $error("key write did not reset block");

    AST_BAD_KEY: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !key_hit |=> !soft_reset_q)
        else $error("soft reset without key");

    AST_SR_READ_ZERO: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_req.rd && i_req.addr == sis_pkg::ADDR_SOFT_RESET |=> o_rdata == sis_pkg::READ_ZERO)
        else $error("soft reset register read nonzero");

    AST_IRQ_A: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        interrupt_enable_a_q[sis_pkg::BIT_VSEQ] && system_status_a_q[sis_pkg::BIT_VSEQ] |-> o_interrupt_out_a)
        else $error("interrupt a mismatch");

    AST_IRQ_B: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (|(system_status_b_q & interrupt_enable_b_q)) |-> o_interrupt_out_b)
        else $error("interrupt b missing");

    AST_RC_A: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        rd_a && !rst_all |=> o_rdata == $past(system_status_a_q) && system_status_a_q == $past(cond_a_vec))
        else $error("status a read clear wrong");

    AST_RC_B: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        rd_b && !rst_all |=> system_status_b_q == $past(cond_b_vec))
        else $error("status b read clear wrong");

    AST_STICKY: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_cond_a.vseq && !rst_all |=> system_status_a_q[sis_pkg::BIT_VSEQ])
        else $error("sequence flag not caught");

    AST_WARN: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_cond_a.csum_b |-> o_warning_out)
        else $error("warning not raised with checksum error");

    AST_IRQ_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_interrupt_out_a && !rd_a && !rst_all && !i_req.wr |=> o_interrupt_out_a)
        else $error("interrupt a dropped while flag set");

    // A rejected key must leave both enable registers as they were; only the exact key may clear them.
    AST_BAD_KEY_KEEP: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_req.wr && i_req.addr == sis_pkg::ADDR_SOFT_RESET && !key_hit && !rst_all
        |=> $stable(interrupt_enable_a_q) && $stable(interrupt_enable_b_q))
        else $error("non-key write changed enables");

    AST_SR_CLEAR_B: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        soft_reset_q |=> system_status_b_q == sis_pkg::REG_RESET_VAL
            && interrupt_enable_b_q == sis_pkg::REG_RESET_VAL)
        else $error("soft reset left status b or enable b set");

    AST_RDATA_IDLE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_req.rd |=> o_rdata == sis_pkg::READ_ZERO)
        else $error("read data shown without a read");

    AST_RC_A_EMPTY: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        rd_a && !rst_all && cond_a_vec == sis_pkg::REG_RESET_VAL
        |=> system_status_a_q == sis_pkg::REG_RESET_VAL)
        else $error("status a not cleared by read");

    AST_RESERVED_A: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (system_status_a_q & ~sis_pkg::STATUS_A_MASK) == sis_pkg::REG_RESET_VAL)
        else $error("reserved status a bit set");

    AST_CSUM_A: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_cond_a.csum_a && !rst_all |=> system_status_a_q[sis_pkg::BIT_CSUM_A])
        else $error("checksum a flag not caught");

    AST_CSUM_B: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_cond_a.csum_b && !rst_all |=> system_status_a_q[sis_pkg::BIT_CSUM_B])
        else $error("checksum b flag not caught");

    AST_CSUM_C: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_cond_a.csum_c && !rst_all |=> system_status_a_q[sis_pkg::BIT_CSUM_C])
        else $error("checksum c flag not caught");

    AST_CSUM_D: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_cond_a.csum_d && !rst_all |=> system_status_a_q[sis_pkg::BIT_CSUM_D])
        else $error("checksum d flag not caught");

    AST_WARN_ANY: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        |(cond_a_vec & sis_pkg::CSUM_MASK) |-> o_warning_out)
        else $error("warning missing for live checksum error");

    AST_ISEQ: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_cond_a.iseq && !rst_all |=> system_status_a_q[sis_pkg::BIT_ISEQ])
        else $error("current sequence flag not caught");

    AST_SAG: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_cond_a.sag && !rst_all |=> system_status_a_q[sis_pkg::BIT_SAG])
        else $error("sag flag not caught");

    AST_PLOSS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_cond_a.ploss && !rst_all |=> system_status_a_q[sis_pkg::BIT_PLOSS])
        else $error("phase loss flag not caught");

    AST_ENABLE_MASK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (interrupt_enable_a_q & ~sis_pkg::STATUS_A_MASK) == sis_pkg::REG_RESET_VAL)
        else $error("reserved enable a bit set");

    AST_ENABLE_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_req.wr && i_req.addr == sis_pkg::ADDR_ENABLE_A && !rst_all
        |=> interrupt_enable_a_q == ($past(i_req.wdata) & sis_pkg::STATUS_A_MASK))
        else $error("enable a write not taken");

    AST_RESERVED_B: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (system_status_b_q & ~sis_pkg::STATUS_B_MASK) == sis_pkg::REG_RESET_VAL)
        else $error("reserved status b bit set");

    // An enabled live condition must raise the pin one edge later, unless a clear or any register write intervenes.
    AST_IRQ_A_RISE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        |(cond_a_vec & interrupt_enable_a_q) && !rst_all && !i_req.wr |=> o_interrupt_out_a)
        else $error("interrupt a not raised");

    AST_IRQ_B_RISE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        |(cond_b_vec & interrupt_enable_b_q) && !rst_all && !i_req.wr |=> o_interrupt_out_b)
        else $error("interrupt b not raised");

    AST_IRQ_A_DROP: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        rd_a && !rst_all && cond_a_vec == sis_pkg::REG_RESET_VAL |=> !o_interrupt_out_a)
        else $error("interrupt a stayed high after clearing read");

    AST_IRQ_B_DROP: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        rd_b && !rst_all && cond_b_vec == sis_pkg::REG_RESET_VAL |=> !o_interrupt_out_b)
        else $error("interrupt b stayed high after clearing read");
endmodule

// ---- testbench/sis_host_model.sv ----
// Host controller model that issues register reads and writes.
`timescale 1ns/1ps
module sis_host_model (
    output sis_pkg::sis_req_t                o_req,
    input  wire logic                        i_clk_sys,
    input  wire logic [sis_pkg::SIS_DW-1:0]  i_rdata
);
    initial begin
        o_req = '0;
    end
    // The strobe is dropped at the edge that takes it, so each request lasts exactly one cycle.
    task automatic bus_write(input logic [7:0] addr, input logic [15:0] data);
        @(posedge i_clk_sys);
        o_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge i_clk_sys);
        o_req <= '0;
    endtask
    task automatic bus_read(input logic [7:0] addr, output logic [15:0] data);
        @(posedge i_clk_sys);
        o_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
        @(posedge i_clk_sys);
        o_req <= '0;
        #1;
        data = i_rdata;
    endtask
    task automatic soft_reset();
        bus_write(8'h00, sis_pkg::SOFT_RESET_KEY);
    endtask
endmodule

// ---- testbench/test_status_irq_soft_reset_key.sv ----
// Self-checking bench for the status, interrupt and soft reset block.
`timescale 1ns/1ps
module test_status_irq_soft_reset_key;
    logic                  i_clk_sys;
    logic                  i_rst;
    sis_pkg::sis_req_t     req;
    sis_pkg::sis_cond_a_t  cond_a;
    logic [15:0]           cond_b;
    logic [15:0]           rdata;
    logic [15:0]           rd_val;
    logic                  irq_a;
    logic                  irq_b;
    logic                  warn;
    logic                  srst;
    int                    err_count;
    int                    num_checks;
    int                    bit_pos [8] = '{14, 12, 10, 8, 7, 6, 3, 2};

    sis_status_irq u_sis_status_irq (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req(req), .o_rdata(rdata),
        .i_cond_a(cond_a), .i_cond_b(cond_b), .o_interrupt_out_a(irq_a), .o_interrupt_out_b(irq_b),
        .o_warning_out(warn), .o_soft_reset(srst));
    sis_host_model u_sis_host_model (.o_req(req), .i_clk_sys(i_clk_sys), .i_rdata(rdata));

    always #5 i_clk_sys = ~i_clk_sys;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_check(input logic [7:0] addr, input logic [15:0] exp);
        u_sis_host_model.bus_read(addr, rd_val);
        check(rd_val, exp);
    endtask
    task automatic pulse(input logic [7:0] a, input logic [15:0] b);
        @(posedge i_clk_sys);
        cond_a <= sis_pkg::sis_cond_a_t'(a);
        cond_b <= b;
        @(posedge i_clk_sys);
        cond_a <= '0;
        cond_b <= 16'h0000;
        #1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        i_clk_sys = 1'b0;
        i_rst = 1'b1;
        cond_a = '0;
        cond_b = 16'h0000;
        err_count = 0;
        num_checks = 0;
        repeat (10) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        rd_check(8'h00, 16'h0000);
        rd_check(8'h01, 16'h0000);
        rd_check(8'h03, 16'h0000);
        rd_check(8'h04, 16'h0000);
        rd_check(8'h02, 16'h0000);
        rd_check(8'h05, 16'h0000);
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            pulse(8'h80 >> k, 16'h0000);
            check({14'h0, irq_a, warn}, {15'h0, 1'(k < 4)});
            rd_check(8'h01, 16'h0001 << bit_pos[k]);
            rd_check(8'h01, 16'h0000);
            check({15'h0, warn}, 16'h0000);
        end
        $display("test status flags done");
        u_sis_host_model.bus_write(8'h03, 16'h0080);
        pulse(8'h01, 16'h0000);
        check({15'h0, irq_a}, 16'h0000);
        pulse(8'h08, 16'h0000);
        check({15'h0, irq_a}, 16'h0001);
        u_sis_host_model.bus_write(8'h03, 16'h0000);
        #1;
        check({15'h0, irq_a}, 16'h0000);
        u_sis_host_model.bus_write(8'h03, 16'h0080);
        #1;
        check({15'h0, irq_a}, 16'h0001);
        rd_check(8'h01, 16'h0084);
        check({15'h0, irq_a}, 16'h0000);
        $display("test interrupt a done");
        u_sis_host_model.bus_write(8'h04, 16'h8000);
        pulse(8'h00, 16'h7101);
        check({15'h0, irq_b}, 16'h0000);
        pulse(8'h00, 16'h8000);
        check({15'h0, irq_b}, 16'h0001);
        rd_check(8'h02, 16'hC001);
        check({15'h0, irq_b}, 16'h0000);
        rd_check(8'h02, 16'h0000);
        $display("test interrupt b done");
        u_sis_host_model.bus_write(8'h03, 16'h0044);
        rd_check(8'h03, 16'h0044);
        u_sis_host_model.bus_write(8'h00, 16'h789B);
        #1;
        check({15'h0, srst}, 16'h0000);
        rd_check(8'h00, 16'h0000);
        rd_check(8'h03, 16'h0044);
        u_sis_host_model.bus_write(8'h04, 16'h0200);
        pulse(8'h04, 16'h0200);
        check({14'h0, irq_a, irq_b}, 16'h0003);
        u_sis_host_model.soft_reset();
        #1;
        check({15'h0, srst}, 16'h0001);
        @(posedge i_clk_sys);
        #1;
        check({13'h0, irq_a, irq_b, srst}, 16'h0000);
        rd_check(8'h03, 16'h0000);
        rd_check(8'h04, 16'h0000);
        rd_check(8'h02, 16'h0000);
        rd_check(8'h01, 16'h0000);
        $display("test soft reset done");
        tally_and_finish();
    end

    // A hang anywhere above is cut short here and counted as a mismatch.
    initial begin
        #200000;
        err_count++;
        tally_and_finish();
    end
endmodule
